// ==== rtl/crac_regs.svh ====
// Constants of the core register access block.
// Assumes inclusion by bare name from the rtl directory.
`ifndef CRAC_REGS_SVH
`define CRAC_REGS_SVH
// Software port byte offsets; bit 7 of the address selects the general registers
`define CRAC_A_CFLAGS 8'h00
`define CRAC_A_STATE 8'h04
`define CRAC_A_IER 8'h08
`define CRAC_A_STATUS 8'h0C
`define CRAC_A_CTRL 8'h10
`define CRAC_A_GR_SEL 7
`define CRAC_A_GR_IDX 6:2
// Special register numbers
`define CRAC_SPR_IER 10'h001
`define CRAC_SPR_USER 10'h100
`define CRAC_SPR_SR0 10'h01A
`define CRAC_SPR_SR1 10'h01B
`define CRAC_SPR_GEN_HI 8'h44
`define CRAC_SPR_VER 10'h11F
// Arbitrary version value, names no real part
`define CRAC_VERSION 32'h0000_C0DE
// Special register slots
`define CRAC_SLOT_IER 3'h0
`define CRAC_SLOT_USER 3'h1
`define CRAC_SLOT_SR0 3'h2
`define CRAC_SLOT_SR1 3'h3
`define CRAC_SLOT_GEN 1'b1
// Processor state word: only two bits implemented
`define CRAC_STATE_EE 15
`define CRAC_STATE_PR 14
`define CRAC_STATE_MASK 32'h0000_C000
`define CRAC_STATE_RST 32'h0000_0000
// Integer exception register fields
`define CRAC_IER_SO 31
`define CRAC_IER_OV 30
`define CRAC_IER_CA 29
`define CRAC_IER_MASK 32'hE000_007F
// Control and status
`define CRAC_CTRL_DCR 0
`define CRAC_CTRL_RST 1'b1
`define CRAC_ZERO 32'h0000_0000
// Bit 0 is the MSB: positions count down from here
`define CRAC_MSB_POS 5'h1F
`define CRAC_F0_BASE 5'h1C
// Immediate operand fields
`define CRAC_IMM_FUNC 18:15
`define CRAC_IMM_BT 14:10
`define CRAC_IMM_BA 9:5
`define CRAC_IMM_BB 4:0
`define CRAC_IMM_FDST 7:5
`define CRAC_IMM_FSRC 2:0
`define CRAC_IMM_WANT 5
`define CRAC_IMM_REC 0
`endif

// ==== rtl/crac_pkg.sv ====
// Types shared by the core register access block.
// Assumes crac_regs.svh supplies all numeric constants.
package crac_pkg;
  typedef enum logic [4:0] {
    CRAC_OP_NOP, CRAC_OP_LOAD, CRAC_OP_STORE, CRAC_OP_ADD,
    CRAC_OP_MTSPR, CRAC_OP_MFSPR, CRAC_OP_MTSTATE, CRAC_OP_MFSTATE,
    CRAC_OP_WREE_REG, CRAC_OP_WREE_IMM, CRAC_OP_MTDCR, CRAC_OP_MFDCR,
    CRAC_OP_CR_LOGIC, CRAC_OP_CR_MOVE, CRAC_OP_BRANCH,
    CRAC_OP_INT_ENTRY, CRAC_OP_INT_RETURN
  } crac_op_t;
  typedef enum logic [1:0] {CRAC_SZ_BYTE, CRAC_SZ_HALF, CRAC_SZ_WORD} crac_size_t;
  typedef struct packed {
    logic hit;
    logic [2:0] slot;
    logic priv;
    logic ro;
    logic ver;
  } crac_spr_t;
endpackage

// ==== rtl/crac_byte_steer.sv ====
// Byte lane steering between data lanes and a register.
// Assumes lanes hold the lowest-address byte in the operand's top byte.
`timescale 1ns/1ns
module crac_byte_steer (
  input wire logic [31:0] data_in,
  input wire crac_pkg::crac_size_t size_in,
  input wire logic swap_in,
  output logic [31:0] data_out
);
  import crac_pkg::*;
  // Same mapping serves load and store: the reversal is its own inverse
  always_comb begin
    case (size_in)
      CRAC_SZ_HALF: data_out = swap_in ? {16'h0000, data_in[7:0], data_in[15:8]}
                                       : {16'h0000, data_in[15:0]};
      CRAC_SZ_WORD: data_out = swap_in ? {data_in[7:0], data_in[15:8],
                                          data_in[23:16], data_in[31:24]} : data_in;
      default: data_out = {24'h00_0000, data_in[7:0]}; // Single bytes never move
    endcase
  end
endmodule

// ==== rtl/crac_core.sv ====
// Architected register set of the core and the access paths to it.
// Assumes one pipeline op per cycle, no op on the cycle after a device-control read.
//
// Behaviour
// - Byte-reverse on big endian page acts as ordinary little endian access.
// - Byte-reverse on little endian page acts as ordinary big endian access.
// - Reserved fields written zero; they read zero here.
// - Every architected register is 32 bits, bit 0 most significant.
// - Thirty-two 32-bit general registers filled by loads, emptied by stores.
// - General registers source and sink moves to other registers.
// - Condition flags register holds eight independent 4-bit fields, 0 to 7.
// - Branch tests any single flag bit; bit logic and field moves supported.
// - Special registers move both ways; some change as side effect.
// - Adds update carry and overflow in integer exception register.
// - State word written from and read into a general register.
// - Interrupt enable set or cleared atomically, register or immediate.
// - Interrupt entry saves and alters the state word; return restores it.
// - Device control registers sit outside; moves reach them by address.
// - Supervisor registers only for privileged code; user registers for both.
// - Registers are read-write unless classed read-only or write-only.
// - Ordinary access reverses within the operand for little endian pages.
`timescale 1ns/1ns
`include "crac_regs.svh"
module crac_core (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic op_valid_in,
  input wire crac_pkg::crac_op_t op_kind_in,
  input wire logic [4:0] op_rt_in,
  input wire logic [4:0] op_ra_in,
  input wire logic [4:0] op_rb_in,
  input wire logic [9:0] op_num_in,
  input wire logic [31:0] op_imm_in,
  input wire crac_pkg::crac_size_t op_size_in,
  input wire logic op_rev_in,
  input wire logic page_le_in,
  input wire logic [31:0] mem_rdata_in,
  input wire logic [31:0] dcr_rdata_in,
  input wire logic [7:0] bus_addr_in,
  input wire logic [31:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [31:0] bus_rdata_out,
  output logic [31:0] mem_wdata_out,
  output logic mem_wr_out,
  output logic [9:0] dcr_addr_out,
  output logic [31:0] dcr_wdata_out,
  output logic dcr_wr_out,
  output logic dcr_rd_out,
  output logic [31:0] op_result_out,
  output logic op_done_out,
  output logic branch_taken_out,
  output logic priv_fault_out,
  output logic user_mode_out,
  output logic async_int_en_out
);
  import crac_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Flag bit n lives at vector position 31-n
  function automatic logic [4:0] crac_bitpos(input logic [4:0] idx);
    crac_bitpos = `CRAC_MSB_POS - idx;
  endfunction

  // Field f occupies positions base+3 down to base
  function automatic logic [4:0] crac_fbase(input logic [2:0] f);
    crac_fbase = `CRAC_F0_BASE - {f, 2'h0};
  endfunction

  // Special register decode
  function automatic crac_spr_t crac_spr_decode(input logic [9:0] num);
    crac_spr_t r;
    r = '{hit: 1'b1, slot: `CRAC_SLOT_IER, priv: 1'b1, ro: 1'b0, ver: 1'b0};
    case (num)
      `CRAC_SPR_IER: r.priv = 1'b0;
      `CRAC_SPR_USER: begin
        r.slot = `CRAC_SLOT_USER;
        r.priv = 1'b0;
      end
      `CRAC_SPR_SR0: r.slot = `CRAC_SLOT_SR0;
      `CRAC_SPR_SR1: r.slot = `CRAC_SLOT_SR1;
      `CRAC_SPR_VER: begin
        r.ro = 1'b1;
        r.ver = 1'b1;
      end
      default: begin
        if (num[9:2] == `CRAC_SPR_GEN_HI) begin
          r.slot = {`CRAC_SLOT_GEN, num[1:0]};
        end else begin
          r.hit = 1'b0; // Unimplemented number reads as zero
        end
      end
    endcase
    crac_spr_decode = r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [31:0] gr_q [0:31];
  logic [31:0] spr_q [0:7];
  logic [31:0] cr_q;
  logic [31:0] state_q;
  logic ctrl_dcr_en_q;
  logic [15:0] fault_cnt_q;
  logic [4:0] fault_op_q;
  logic mfdcr_pend_q;
  logic [4:0] mfdcr_rt_q;

  //////////////////////////////////////////////////////////////////////////////
  // Decode

  crac_spr_t special_register;
  logic user;
  logic priv_op;
  logic fault;
  logic go;
  logic [31:0] src_a;
  logic [31:0] src_b;
  logic [31:0] src_t;
  logic [32:0] sum;
  logic ovf;
  logic [31:0] spr_rd;
  logic [31:0] steer_in;
  logic [31:0] steer_out;
  logic swap;
  logic gr_we;
  logic [31:0] gr_wd;
  logic cr_a;
  logic cr_b;
  logic [3:0] cr0_rec;
  logic [3:0] func;

  assign special_register = crac_spr_decode(op_num_in);
  assign user = state_q[`CRAC_STATE_PR];
  assign src_a = gr_q[op_ra_in];
  assign src_b = gr_q[op_rb_in];
  assign src_t = gr_q[op_rt_in];
  assign func = op_imm_in[`CRAC_IMM_FUNC];

  // Privileged op classes
  always_comb begin
    case (op_kind_in)
      CRAC_OP_MTSTATE, CRAC_OP_MFSTATE, CRAC_OP_WREE_REG, CRAC_OP_WREE_IMM,
      CRAC_OP_MTDCR, CRAC_OP_MFDCR, CRAC_OP_INT_RETURN: priv_op = 1'b1;
      CRAC_OP_MTSPR, CRAC_OP_MFSPR: priv_op = special_register.priv;
      default: priv_op = 1'b0;
    endcase
  end

  // A blocked op changes nothing but the fault report
  assign fault = op_valid_in & user & priv_op;
  assign go = op_valid_in & ~fault;

  // Carry out and signed overflow of the add
  assign sum = {1'b0, src_a} + {1'b0, src_b};
  assign ovf = (src_a[31] == src_b[31]) & (sum[31] != src_a[31]);
  assign cr0_rec = {sum[31], ~sum[31] & (sum[31:0] != `CRAC_ZERO),
                    sum[31:0] == `CRAC_ZERO, spr_q[`CRAC_SLOT_IER][`CRAC_IER_SO] | ovf};

  assign spr_rd = special_register.ver ? `CRAC_VERSION : (special_register.hit ? spr_q[special_register.slot] : `CRAC_ZERO);

  // Byte-reverse flips the page order
  assign swap = page_le_in ^ op_rev_in;
  assign steer_in = (op_kind_in == CRAC_OP_STORE) ? src_t : mem_rdata_in;

  crac_byte_steer u_steer (
    .data_in(steer_in),
    .size_in(op_size_in),
    .swap_in(swap),
    .data_out(steer_out)
  );

  assign cr_a = cr_q[crac_bitpos(op_imm_in[`CRAC_IMM_BA])];
  assign cr_b = cr_q[crac_bitpos(op_imm_in[`CRAC_IMM_BB])];

  // General register write-back selection
  always_comb begin
    gr_we = 1'b0;
    gr_wd = `CRAC_ZERO;
    if (go) begin
      case (op_kind_in)
        CRAC_OP_LOAD: begin
          gr_we = 1'b1;
          gr_wd = steer_out;
        end
        CRAC_OP_ADD: begin
          gr_we = 1'b1;
          gr_wd = sum[31:0];
        end
        CRAC_OP_MFSPR: begin
          gr_we = 1'b1;
          gr_wd = spr_rd;
        end
        CRAC_OP_MFSTATE: begin
          gr_we = 1'b1;
          gr_wd = state_q & `CRAC_STATE_MASK;
        end
        default: begin
          gr_we = 1'b0;
          gr_wd = `CRAC_ZERO;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // General registers

  // Pipeline write, then late device-control data, then the software port
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      for (int i = 0; i < 32; i++) begin
        gr_q[i] <= `CRAC_ZERO;
      end
    end else begin
      if (bus_wr_in && bus_addr_in[`CRAC_A_GR_SEL]) begin
        gr_q[bus_addr_in[`CRAC_A_GR_IDX]] <= bus_wdata_in;
      end
      if (mfdcr_pend_q) begin
        gr_q[mfdcr_rt_q] <= dcr_rdata_in;
      end
      if (gr_we) begin
        gr_q[op_rt_in] <= gr_wd;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Special registers

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      for (int i = 0; i < 8; i++) begin
        spr_q[i] <= `CRAC_ZERO;
      end
    end else begin
      if (bus_wr_in && bus_addr_in == `CRAC_A_IER) begin
        spr_q[`CRAC_SLOT_IER] <= bus_wdata_in & `CRAC_IER_MASK;
      end
      // Writes to the read-only version number fall through unheard
      if (go && op_kind_in == CRAC_OP_MTSPR && special_register.hit && !special_register.ro) begin
        spr_q[special_register.slot] <= (special_register.slot == `CRAC_SLOT_IER) ? (src_a & `CRAC_IER_MASK)
                                                         : src_a;
      end
      // Side effect of the add; summary overflow stays set until rewritten
      if (go && op_kind_in == CRAC_OP_ADD) begin
        spr_q[`CRAC_SLOT_IER][`CRAC_IER_CA] <= sum[32];
        spr_q[`CRAC_SLOT_IER][`CRAC_IER_OV] <= ovf;
        spr_q[`CRAC_SLOT_IER][`CRAC_IER_SO] <= spr_q[`CRAC_SLOT_IER][`CRAC_IER_SO] | ovf;
      end
      if (go && op_kind_in == CRAC_OP_INT_ENTRY) begin
        spr_q[`CRAC_SLOT_SR0] <= op_imm_in;
        spr_q[`CRAC_SLOT_SR1] <= state_q & `CRAC_STATE_MASK;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Processor state word

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_q <= `CRAC_STATE_RST;
    end else begin
      if (bus_wr_in && bus_addr_in == `CRAC_A_STATE) begin
        state_q <= bus_wdata_in & `CRAC_STATE_MASK;
      end
      if (go) begin
        case (op_kind_in)
          CRAC_OP_MTSTATE: state_q <= src_a & `CRAC_STATE_MASK;
          // Single write of one bit, so no other bit can change underneath
          CRAC_OP_WREE_REG: state_q[`CRAC_STATE_EE] <= src_a[`CRAC_STATE_EE];
          CRAC_OP_WREE_IMM: state_q[`CRAC_STATE_EE] <= op_imm_in[`CRAC_STATE_EE];
          CRAC_OP_INT_ENTRY: state_q <= `CRAC_STATE_RST;
          CRAC_OP_INT_RETURN: state_q <= spr_q[`CRAC_SLOT_SR1] & `CRAC_STATE_MASK;
          default: state_q <= state_q;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Condition flags register

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cr_q <= `CRAC_ZERO;
    end else begin
      if (bus_wr_in && bus_addr_in == `CRAC_A_CFLAGS) begin
        cr_q <= bus_wdata_in;
      end
      if (go) begin
        case (op_kind_in)
          // Truth table indexed by the two source bits
          CRAC_OP_CR_LOGIC: cr_q[crac_bitpos(op_imm_in[`CRAC_IMM_BT])] <= func[{cr_a, cr_b}];
          CRAC_OP_CR_MOVE: cr_q[crac_fbase(op_imm_in[`CRAC_IMM_FDST]) +: 4]
                           <= cr_q[crac_fbase(op_imm_in[`CRAC_IMM_FSRC]) +: 4];
          CRAC_OP_ADD: begin
            if (op_imm_in[`CRAC_IMM_REC]) begin
              cr_q[crac_fbase(3'h0) +: 4] <= cr0_rec;
            end
          end
          default: cr_q <= cr_q;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Device control moves, memory store, op report

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      dcr_wr_out <= 1'b0;
      dcr_rd_out <= 1'b0;
      dcr_addr_out <= 10'h000;
      dcr_wdata_out <= `CRAC_ZERO;
      mfdcr_pend_q <= 1'b0;
      mfdcr_rt_q <= 5'h00;
    end else begin
      // With the path disabled the moves complete as no-ops
      dcr_wr_out <= go & ctrl_dcr_en_q & (op_kind_in == CRAC_OP_MTDCR);
      dcr_rd_out <= go & ctrl_dcr_en_q & (op_kind_in == CRAC_OP_MFDCR);
      mfdcr_pend_q <= go & ctrl_dcr_en_q & (op_kind_in == CRAC_OP_MFDCR);
      mfdcr_rt_q <= op_rt_in;
      dcr_addr_out <= op_num_in;
      dcr_wdata_out <= src_a;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      mem_wr_out <= 1'b0;
      mem_wdata_out <= `CRAC_ZERO;
    end else begin
      mem_wr_out <= go & (op_kind_in == CRAC_OP_STORE);
      mem_wdata_out <= steer_out;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      op_done_out <= 1'b0;
      op_result_out <= `CRAC_ZERO;
      branch_taken_out <= 1'b0;
      priv_fault_out <= 1'b0;
      user_mode_out <= 1'b0;
      async_int_en_out <= 1'b0;
    end else begin
      op_done_out <= go;
      op_result_out <= (op_kind_in == CRAC_OP_INT_RETURN) ? spr_q[`CRAC_SLOT_SR0] : gr_wd;
      branch_taken_out <= go & (op_kind_in == CRAC_OP_BRANCH) &
                          (cr_a == op_imm_in[`CRAC_IMM_WANT]);
      priv_fault_out <= fault;
      user_mode_out <= state_q[`CRAC_STATE_PR];
      async_int_en_out <= state_q[`CRAC_STATE_EE];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software port: control, fault status, read-back

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ctrl_dcr_en_q <= `CRAC_CTRL_RST;
    end else if (bus_wr_in && bus_addr_in == `CRAC_A_CTRL) begin
      ctrl_dcr_en_q <= bus_wdata_in[`CRAC_CTRL_DCR];
    end
  end

  // Count saturates rather than wrapping so a storm stays visible
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      fault_cnt_q <= 16'h0000;
      fault_op_q <= 5'h00;
    end else if (fault) begin
      fault_cnt_q <= (&fault_cnt_q) ? fault_cnt_q : fault_cnt_q + 16'h0001;
      fault_op_q <= op_kind_in;
    end else if (bus_wr_in && bus_addr_in == `CRAC_A_STATUS) begin
      fault_cnt_q <= 16'h0000;
    end
  end

  // Data stand one cycle; reserved bits read zero
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      bus_rdata_out <= `CRAC_ZERO;
    end else begin
      bus_rdata_out <= `CRAC_ZERO;
      if (bus_rd_in) begin
        if (bus_addr_in[`CRAC_A_GR_SEL]) begin
          bus_rdata_out <= gr_q[bus_addr_in[`CRAC_A_GR_IDX]];
        end else begin
          case (bus_addr_in)
            `CRAC_A_CFLAGS: bus_rdata_out <= cr_q;
            `CRAC_A_STATE: bus_rdata_out <= state_q & `CRAC_STATE_MASK;
            `CRAC_A_IER: bus_rdata_out <= spr_q[`CRAC_SLOT_IER];
            `CRAC_A_STATUS: bus_rdata_out <= {11'h000, fault_op_q, fault_cnt_q};
            `CRAC_A_CTRL: bus_rdata_out <= {31'h0000_0000, ctrl_dcr_en_q};
            default: bus_rdata_out <= `CRAC_ZERO;
          endcase
        end
      end
    end
  end
endmodule

// ==== bench/crac_core_assertions.sv ====
// Port-level checks for the core register access block.
// Assumes one clock domain and a synchronous active high reset.
`timescale 1ns/1ns
module crac_core_assertions (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic op_valid_in,
  input wire crac_pkg::crac_op_t op_kind_in,
  input wire logic [9:0] op_num_in,
  input wire crac_pkg::crac_size_t op_size_in,
  input wire logic op_rev_in,
  input wire logic page_le_in,
  input wire logic [31:0] mem_rdata_in,
  input wire logic [7:0] bus_addr_in,
  input wire logic [31:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  input wire logic [31:0] bus_rdata_out,
  input wire logic mem_wr_out,
  input wire logic [9:0] dcr_addr_out,
  input wire logic dcr_wr_out,
  input wire logic dcr_rd_out,
  input wire logic [31:0] op_result_out,
  input wire logic op_done_out,
  input wire logic branch_taken_out,
  input wire logic priv_fault_out
);
  import crac_pkg::*;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////
  // Whole word lane reversal
  function automatic logic [31:0] rev4(logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  // Op steps; the bus pair avoids pipeline writes, which win
  sequence s_op(k);
    op_valid_in && op_kind_in == k;
  endsequence
  sequence s_word_load;
    op_valid_in && op_kind_in == CRAC_OP_LOAD && op_size_in == CRAC_SZ_WORD;
  endsequence
  sequence s_gr_write_read;
    !op_valid_in && bus_wr_in && bus_addr_in[7] ##1
    !op_valid_in && bus_rd_in && bus_addr_in == $past(bus_addr_in);
  endsequence
  a_load_lanes: assert property (
    s_word_load ##1 op_done_out |-> op_result_out ==
    ($past(page_le_in ^ op_rev_in) ? rev4($past(mem_rdata_in)) : $past(mem_rdata_in)))
    else $error("word load lanes wrong");
  a_gr_echo: assert property (
    s_gr_write_read |=> bus_rdata_out == $past(bus_wdata_in, 2))
    else $error("general register did not hold the written word");
  a_store_pulse: assert property (
    s_op(CRAC_OP_STORE) |=> mem_wr_out && op_done_out)
    else $error("store gave no memory write");
  a_dcr_write: assert property (
    s_op(CRAC_OP_MTDCR) ##1 op_done_out |-> dcr_wr_out && dcr_addr_out == $past(op_num_in))
    else $error("device control write missing or misaddressed");
  a_dcr_read: assert property (
    dcr_rd_out |-> $past(op_kind_in) == CRAC_OP_MFDCR && dcr_addr_out == $past(op_num_in))
    else $error("device control read without its op");
  a_fault_quiet: assert property (
    priv_fault_out |-> !op_done_out && !mem_wr_out && !dcr_wr_out && !dcr_rd_out)
    else $error("faulted op still had an effect");
  a_user_ops: assert property (
    op_valid_in && op_kind_in inside {CRAC_OP_LOAD, CRAC_OP_ADD, CRAC_OP_BRANCH,
    CRAC_OP_CR_MOVE} |=> op_done_out && !priv_fault_out)
    else $error("unprivileged op was refused");
  a_branch_src: assert property (
    branch_taken_out |-> $past(op_valid_in) && $past(op_kind_in) == CRAC_OP_BRANCH)
    else $error("branch taken without a branch op");
  a_bus_idle: assert property (
    bus_rd_in ##1 !bus_rd_in |=> bus_rdata_out == 32'h0)
    else $error("read data stood longer than one cycle");
endmodule
bind crac_core crac_core_assertions u_crac_core_assertions (.*);

// ==== bench/crac_dcr_model.sv ====
// Device control register space that sits outside the core.
// Assumes read data is taken in the same cycle the read strobe is high.
`timescale 1ns/1ns
module crac_dcr_model (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [9:0] dcr_addr_in,
  input wire logic [31:0] dcr_wdata_in,
  input wire logic dcr_wr_in,
  input wire logic dcr_rd_in,
  output logic [31:0] dcr_rdata_out
);
  logic [31:0] regs_q [4];
  logic [31:0] last_q;
  // Low address bits only: aliasing expected
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) regs_q <= '{default: 32'h0};
    else if (dcr_wr_in) regs_q[dcr_addr_in[1:0]] <= dcr_wdata_in;
  end
  // Idle cycles show the last answer inverted
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) last_q <= 32'h0;
    else if (dcr_rd_in) last_q <= dcr_rdata_out;
  end
  // Stale data would hide a late sample
  assign dcr_rdata_out = dcr_rd_in ? regs_q[dcr_addr_in[1:0]] : ~last_q;
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the core register access block.
// Assumes the header on the include path and the model beside it.
`timescale 1ns/1ns
`include "crac_regs.svh"
module testbench;
  import crac_pkg::*;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, op_valid_in = 1'b0;
  logic [1:0] rd_taken = 2'b00;
  crac_op_t op_kind_in = CRAC_OP_NOP;
  crac_size_t op_size_in = CRAC_SZ_WORD;
  logic [4:0] op_r = 5'h0;
  logic [9:0] op_num_in = 10'h0;
  logic [31:0] op_imm_in = 32'h0, mem_rdata_in = 32'h0, bus_wdata_in = 32'h0;
  logic op_rev_in = 1'b0, page_le_in = 1'b0, bus_wr_in = 1'b0, bus_rd_in = 1'b0;
  logic [7:0] bus_addr_in = 8'h0;
  logic [31:0] dcr_rdata_in, bus_rdata_out, mem_wdata_out, dcr_wdata_out, op_result_out;
  logic [9:0] dcr_addr_out;
  logic mem_wr_out, dcr_wr_out, dcr_rd_out, op_done_out, branch_taken_out;
  logic priv_fault_out, user_mode_out, async_int_en_out;
  logic [31:0] gm [32];
  logic [31:0] cr, m, ex, rx;
  logic [34:0] e;
  logic [34:0] exp_q [$];
  logic [31:0] bus_q [$], st_q [$];
  integer seed = 32'h8ae8;
  int bad_count = 0, total_checks = 0, i, f;
  always #2 clk_sys_in = ~clk_sys_in;
  crac_core u_crac_core (.*, .op_rt_in(op_r), .op_ra_in(op_r), .op_rb_in(op_r));
  crac_dcr_model u_crac_dcr_model (.clk_sys_in, .reset_in, .dcr_addr_in(dcr_addr_out),
    .dcr_wdata_in(dcr_wdata_out), .dcr_wr_in(dcr_wr_out), .dcr_rd_in(dcr_rd_out),
    .dcr_rdata_out(dcr_rdata_in));
  ////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  // All three strobes set once per call: no double assignment
  task automatic strobe(logic v, logic w, logic r);
    op_valid_in <= v;
    bus_wr_in <= w;
    bus_rd_in <= r;
    @(posedge clk_sys_in);
  endtask
  task automatic bw(logic [7:0] ad, logic [31:0] d);
    bus_addr_in <= ad;
    bus_wdata_in <= d;
    strobe(1'b0, 1'b1, 1'b0);
  endtask
  task automatic br(logic [7:0] ad, logic [31:0] x);
    bus_addr_in <= ad;
    bus_q.push_back(x);
    strobe(1'b0, 1'b0, 1'b1);
  endtask
  // Note: fault, skip, branch, result
  task automatic op(crac_op_t k, logic [4:0] r, logic [9:0] n, logic [31:0] im,
                    logic [34:0] x);
    op_kind_in <= k;
    op_r <= r;
    op_num_in <= n;
    op_imm_in <= im;
    mem_rdata_in <= (k == CRAC_OP_LOAD) ? m : ~mem_rdata_in;
    exp_q.push_back(x);
    strobe(1'b1, 1'b0, 1'b0);
  endtask
  task automatic test_done;
    chk("pending", exp_q.size(), 32'h0);
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Judge results mid-cycle
  always @(posedge clk_sys_in) rd_taken <= {bus_rd_in && bus_addr_in == `CRAC_A_STATE, bus_rd_in};
  always @(negedge clk_sys_in) begin
    if (rd_taken[0]) begin
      rx = bus_q.pop_front();
      chk("bus_rdata", bus_rdata_out, rx);
      if (rd_taken[1]) chk("state_pins", {async_int_en_out, user_mode_out}, rx[15:14]);
    end
    if (mem_wr_out === 1'b1) chk("mem_wdata", mem_wdata_out, st_q.pop_front());
    if (op_done_out === 1'b1 || priv_fault_out === 1'b1) begin
      e = exp_q.pop_front();
      chk("fault", priv_fault_out, e[34]);
      chk("done", op_done_out, !e[34]);
      chk("branch", branch_taken_out, e[32]);
      if (!e[33]) chk("result", op_result_out, e[31:0]);
    end
  end
  initial begin
    repeat (2000) @(posedge clk_sys_in);
    bad_count++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    br(8'h00, 32'h0);
    br(8'h04, 32'h0);
    br(8'h10, 32'h1);
    br(8'h20, 32'h0);
    for (i = 0; i < 32; i++) begin
      gm[i] = $random(seed);
      bw(8'h80 + 8'(4 * i), gm[i]);
      br(8'h80 + 8'(4 * i), gm[i]);
    end
    // All sizes, page orders, reverse forms
    for (i = 0; i < 12; i++) begin
      m = $random(seed);
      f = ((i / 3) % 2) ^ (i / 6);
      op_size_in <= crac_size_t'(i % 3);
      page_le_in <= 1'((i / 3) % 2);
      op_rev_in <= 1'(i / 6);
      case (i % 3)
        0: ex = {24'h0, m[7:0]};
        1: ex = {16'h0, f[0] ? {m[7:0], m[15:8]} : m[15:0]};
        default: ex = f[0] ? {m[7:0], m[15:8], m[23:16], m[31:24]} : m;
      endcase
      gm[i] = ex;
      op(CRAC_OP_LOAD, 5'(i), 10'h0, 32'h0, {3'b000, ex});
    end
    op_size_in <= CRAC_SZ_WORD;
    for (i = 0; i < 4; i++) begin
      page_le_in <= i[0];
      op_rev_in <= i[1];
      m = gm[20 + i];
      st_q.push_back((i[0] ^ i[1]) ? {m[7:0], m[15:8], m[23:16], m[31:24]} : m);
      op(CRAC_OP_STORE, 5'(20 + i), 10'h0, 32'h0, 35'h0);
    end
    // Carry and overflow; summary overflow set too
    bw(8'h94, 32'h8000_0001);
    op(CRAC_OP_ADD, 5'd5, 10'h0, 32'h0, {3'b000, 32'h2});
    br(8'h08, 32'hE000_0000);
    cr = $random(seed);
    bw(8'h00, cr);
    for (i = 0; i < 8; i++) begin
      f = $random(seed) & 32'h0000_00E7;
      cr[31 - 4 * f[7:5] -: 4] = cr[31 - 4 * f[2:0] -: 4];
      op(CRAC_OP_CR_MOVE, 5'd0, 10'h0, f, 35'h0);
      f = $random(seed) & 32'h0007_FFFF;
      cr[31 - f[14:10]] = f[15 + {cr[31 - f[9:5]], cr[31 - f[4:0]]}];
      op(CRAC_OP_CR_LOGIC, 5'd0, 10'h0, f, 35'h0);
    end
    br(8'h00, cr);
    cr = cr ^ 32'h0000_000F;
    bw(8'h00, cr);
    for (i = 0; i < 32; i++)
      op(CRAC_OP_BRANCH, 5'd0, 10'h0, 32'(i) << 5, {2'b00, cr[31 - i] == i[0], 32'h0});
    op(CRAC_OP_MTSPR, 5'd3, 10'h100, 32'h0, 35'h0);
    op(CRAC_OP_MFSPR, 5'd7, 10'h100, 32'h0, {3'b000, gm[3]});
    op(CRAC_OP_MTSPR, 5'd3, 10'h11F, 32'h0, 35'h0);
    op(CRAC_OP_MFSPR, 5'd8, 10'h11F, 32'h0, {3'b000, `CRAC_VERSION});
    op(CRAC_OP_MTDCR, 5'd3, 10'h2, 32'h0, 35'h0);
    op(CRAC_OP_MFDCR, 5'd9, 10'h2, 32'h0, {3'b010, 32'h0});
    strobe(1'b0, 1'b0, 1'b0);
    br(8'hA4, gm[3]);
    bw(8'h04, 32'hFFFF_BFFF);
    br(8'h04, 32'h0000_8000);
    op(CRAC_OP_WREE_IMM, 5'd0, 10'h0, 32'h0, 35'h0);
    br(8'h04, 32'h0);
    bw(8'hA8, 32'h0000_8000);
    op(CRAC_OP_WREE_REG, 5'd10, 10'h0, 32'h0, 35'h0);
    br(8'h04, 32'h0000_8000);
    // User mode vs supervisor resources
    bw(8'hAC, 32'h0000_4000);
    op(CRAC_OP_MTSTATE, 5'd11, 10'h0, 32'h0, 35'h0);
    br(8'h04, 32'h0000_4000);
    op(CRAC_OP_MFSTATE, 5'd12, 10'h0, 32'h0, {3'b110, 32'h0});
    op(CRAC_OP_MTSPR, 5'd3, 10'h01A, 32'h0, {3'b110, 32'h0});
    op(CRAC_OP_MFSPR, 5'd12, 10'h100, 32'h0, {3'b000, gm[3]});
    br(8'h0C, {11'h0, CRAC_OP_MTSPR, 16'h0002});
    op(CRAC_OP_INT_ENTRY, 5'd0, 10'h0, 32'h0000_1234, 35'h0);
    op(CRAC_OP_MFSPR, 5'd13, 10'h01B, 32'h0, {3'b000, 32'h0000_4000});
    op(CRAC_OP_INT_RETURN, 5'd14, 10'h0, 32'h0, {3'b000, 32'h0000_1234});
    op(CRAC_OP_MTDCR, 5'd3, 10'h2, 32'h0, {3'b110, 32'h0});
    op(CRAC_OP_INT_ENTRY, 5'd0, 10'h0, 32'h0, 35'h0);
    op(CRAC_OP_MFSTATE, 5'd15, 10'h0, 32'h0, {3'b000, 32'h0});
    repeat (3) strobe(1'b0, 1'b0, 1'b0);
    test_done();
  end
endmodule
